// ===== perf_event_counter.sv
// Two-channel event-selectable performance counters with break-time
// interrupt gating for the on-chip debug logic.
// Assumes all event inputs come from core logic on clk_i; registers are
// reached over a plain strobe port with read data one cycle later.
//
// Summary of operation
// - Two independent counting channels, each with its own event selection.
// - Each channel counts on CPU clock or scaled by CPU/bus ratio; CPU default.
// - Operand events skip cache-touch accesses and pages with cacheable bit clear.
// - Instruction miss also counts uncached fetches not done in one cycle.
// - Instruction miss also counts misses in the exception overrun fetch.
// - Data and instruction TLB miss events count misses cancelled by exceptions.
// - Cacheable and total fetch events count when a fetch request is accepted.
// - Issue events add two on a dual issue; FPU issue adds two only when both issued slots hold FP opcodes.
// - On fetch exceptions issue and dual-issue events add one to three.
// - FPU issue covers FP comm and status moves and all Fxxx opcodes.
// - Break channel A and B events count emulator-owned matches too.
// - Miss freeze events include internal RAM and internal I/O stalls.
// - Miss freeze events include uncached instruction and operand stalls.
// - Branch freeze adds one per branch unless delay slot runs one cycle late.
// - Branch target miss stalls from second cycle go to instruction fill.
// - Branch freeze counts every kind of branch instruction.
// - Interrupts disabled during break: no NMI, external or peripheral accepted.
// - Enabled without mask level: only NMI accepted during break.
// - With a mask level, levels above it accepted during break, others masked.
// - Mask level defaults to zero; with no level given, no external interrupt is accepted during break.
// - Continuous trace: no user interrupts during command execution or wait.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module perf_event_counter
  import perf_event_counter_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Measurement range
  input wire logic prog_running_i,
  input wire logic brk_cond4_i,
  // Operand side events
  input wire logic opnd_acc_i,
  input wire logic opnd_wr_i,
  input wire logic opnd_cache_area_i,
  input wire logic cache_touch_instruction_i,
  input wire logic page_cacheable_bit_i,
  input wire logic opnd_ram_i,
  input wire logic io_acc_i,
  input wire logic opnd_miss_i,
  input wire logic ofill_cycle_i,
  // Instruction side events
  input wire logic imiss_i,
  input wire logic ifetch_uncached_slow_i,
  input wire logic overrun_imiss_i,
  input wire logic ifetch_accept_i,
  input wire logic ifetch_cache_area_i,
  input wire logic ifill_cycle_i,
  // Translation misses, raised or cancelled alike
  input wire logic dxlate_miss_i,
  input wire logic dxlate_miss_cancel_i,
  input wire logic ixlate_miss_i,
  input wire logic ixlate_miss_cancel_i,
  // Issue slots
  input wire logic issue_v0_i,
  input wire logic issue_v1_i,
  input wire logic [15:0] issue_op0_i,
  input wire logic [15:0] issue_op1_i,
  input wire logic ifetch_exc_i,
  input wire logic [1:0] ifetch_exc_issue_i,
  input wire logic br_issue_i,
  input wire logic br_taken_i,
  input wire logic call_issue_i,
  input wire logic trap_exec_i,
  input wire logic int_taken_i,
  input wire logic nmi_taken_i,
  // Break channel matches
  input wire logic break_chan_a_hit_i,
  input wire logic break_chan_b_hit_i,
  // Freeze causes
  input wire logic frz_imiss_i,
  input wire logic frz_iuncached_i,
  input wire logic frz_iram_io_i,
  input wire logic frz_dmiss_i,
  input wire logic frz_duncached_i,
  input wire logic frz_dram_io_i,
  input wire logic branch_exec_i,
  input wire logic delay_slot_late_i,
  input wire logic exc_freeze_i,
  input wire logic br_target_stall_i,
  // Interrupt gating
  input wire logic in_break_i,
  input wire logic emu_cmd_busy_i,
  input wire logic nmi_req_i,
  input wire logic ext_req_i,
  input wire logic [LEVEL_W-1:0] ext_level_i,
  output logic nmi_accept_o,
  output logic ext_accept_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic is_fp_op(input logic [15:0] op);
    logic [7:0] lo;
    lo = op[7:0];
    is_fp_op = (op[15:12] == 4'hf) ||
               ((op[15:12] == 4'h4) && ((lo == 8'h5a) || (lo == 8'h56) ||
                                        (lo == 8'h6a) || (lo == 8'h66) ||
                                        (lo == 8'h52) || (lo == 8'h62))) ||
               ((op[15:12] == 4'h0) && ((lo == 8'h5a) || (lo == 8'h6a)));
  endfunction : is_fp_op

  function automatic logic [1:0] sel_inc(input logic [CTRL_MODE_W-1:0] mode,
                                         input logic [NUM_MODES-1:0] bits,
                                         input logic [1:0] iss,
                                         input logic [1:0] dual,
                                         input logic [1:0] fp);
    sel_inc = 2'h0;
    if (mode == M_ISSUE) begin
      sel_inc = iss;
    end else if (mode == M_DUAL_ISSUE) begin
      sel_inc = dual;
    end else if (mode == M_FP_ISSUE) begin
      sel_inc = fp;
    end else if (mode < CTRL_MODE_W'(NUM_MODES)) begin
      sel_inc = {1'b0, bits[mode]};
    end
  endfunction : sel_inc

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q [NUM_CHAN];
  logic [CNT_W-1:0] cnt_q [NUM_CHAN];
  logic [CNT_W-1:0] cnt_d [NUM_CHAN];
  logic [RATIO_W:0] presc_q [NUM_CHAN];
  logic [RATIO_W:0] presc_d [NUM_CHAN];
  logic brk_win_q [NUM_CHAN];
  logic [RATIO_W-1:0] ratio_q;
  logic irq_en_q;
  logic level_given_q;
  logic cont_trace_q;
  logic [LEVEL_W-1:0] level_q;
  logic br_stall_seen_q;
  logic brk_cond4_q;
  logic [DATA_W-1:0] rdata_q;
  logic nmi_acc_q;
  logic ext_acc_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic wr_ctrl0 = wr_i && (addr_i == OFS_CH_CTRL0);
  wire logic wr_ctrl1 = wr_i && (addr_i == OFS_CH_CTRL1);
  wire logic wr_cnt0 = wr_i && (addr_i == OFS_CH_COUNT0);
  wire logic wr_cnt1 = wr_i && (addr_i == OFS_CH_COUNT1);
  wire logic wr_ratio = wr_i && (addr_i == OFS_BUS_RATIO);
  wire logic wr_irq = wr_i && (addr_i == OFS_BRK_IRQ_CFG);
  wire logic [NUM_CHAN-1:0] wr_ctrl = {wr_ctrl1, wr_ctrl0};
  wire logic [NUM_CHAN-1:0] wr_cnt = {wr_cnt1, wr_cnt0};
  wire logic [RATIO_W-1:0] ratio_eff = (ratio_q == '0) ? RATIO_RST : ratio_q;

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  wire logic opnd_ok = opnd_acc_i && !cache_touch_instruction_i && page_cacheable_bit_i;
  wire logic opnd_cached = opnd_ok && opnd_cache_area_i;
  wire logic dmiss_ok = opnd_miss_i && !cache_touch_instruction_i && page_cacheable_bit_i;
  wire logic imiss_any = imiss_i || ifetch_uncached_slow_i || overrun_imiss_i;
  wire logic dxlate_any = dxlate_miss_i || dxlate_miss_cancel_i;
  wire logic ixlate_any = ixlate_miss_i || ixlate_miss_cancel_i;
  wire logic fetch_cached = ifetch_accept_i && ifetch_cache_area_i;
  wire logic frz_i_any = frz_imiss_i || frz_iuncached_i || frz_iram_io_i;
  wire logic frz_d_any = frz_dmiss_i || frz_duncached_i || frz_dram_io_i;
  wire logic frz_branch = (branch_exec_i && !delay_slot_late_i) || exc_freeze_i;
  wire logic ifill_any = ifill_cycle_i || (br_target_stall_i && br_stall_seen_q);
  wire logic [1:0] exc_add = (ifetch_exc_issue_i == 2'h0) ? 2'h1 : ifetch_exc_issue_i;
  wire logic [1:0] slot_cnt = {1'b0, issue_v0_i} + {1'b0, issue_v1_i};
  wire logic [1:0] fp_cnt = {1'b0, issue_v0_i && is_fp_op(issue_op0_i)} +
                            {1'b0, issue_v1_i && is_fp_op(issue_op1_i)};
  wire logic [1:0] iss_add = ifetch_exc_i ? exc_add : slot_cnt;
  wire logic [1:0] dual_add = ifetch_exc_i ? exc_add : {1'b0, slot_cnt == 2'h2};

  logic [NUM_MODES-1:0] ev_bits;
  always_comb begin
    ev_bits = '0;
    ev_bits[M_OPND_RD] = opnd_cached && !opnd_wr_i;
    ev_bits[M_OPND_WR] = opnd_cached && opnd_wr_i;
    ev_bits[M_OPND_RW] = opnd_cached;
    ev_bits[M_OPND_RAM] = opnd_ok && opnd_ram_i;
    ev_bits[M_OPND_ALL] = opnd_ok;
    ev_bits[M_IO_ACC] = io_acc_i;
    ev_bits[M_DMISS_RD] = dmiss_ok && !opnd_wr_i;
    ev_bits[M_DMISS_WR] = dmiss_ok && opnd_wr_i;
    ev_bits[M_DMISS_RW] = dmiss_ok;
    ev_bits[M_IMISS] = imiss_any;
    ev_bits[M_DXLATE_MISS] = dxlate_any;
    ev_bits[M_IXLATE_MISS] = ixlate_any;
    ev_bits[M_FETCH_CACHED] = fetch_cached;
    ev_bits[M_FETCH_ALL] = ifetch_accept_i;
    ev_bits[M_BR_ISSUE] = br_issue_i;
    ev_bits[M_BR_TAKEN] = br_taken_i;
    ev_bits[M_CALL_ISSUE] = call_issue_i;
    ev_bits[M_TRAP] = trap_exec_i;
    ev_bits[M_INT] = int_taken_i;
    ev_bits[M_NMI] = nmi_taken_i;
    ev_bits[M_BRK_A] = break_chan_a_hit_i;
    ev_bits[M_BRK_B] = break_chan_b_hit_i;
    ev_bits[M_IFILL] = ifill_any;
    ev_bits[M_OFILL] = ofill_cycle_i;
    ev_bits[M_TIME] = 1'b1;
    ev_bits[M_FRZ_IMISS] = frz_i_any;
    ev_bits[M_FRZ_DMISS] = frz_d_any;
    ev_bits[M_FRZ_BRANCH] = frz_branch;
  end

  // ----------------------------------------------------------------
  // Channel counting
  // ----------------------------------------------------------------
  wire logic brk_cond4_rise = brk_cond4_i && !brk_cond4_q;
  logic [NUM_CHAN-1:0] active;
  logic [1:0] inc [NUM_CHAN];
  logic [RATIO_W:0] psum [NUM_CHAN];

  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      active[c] = ctrl_q[c][CTRL_EN_BIT] &&
                  (ctrl_q[c][CTRL_RANGE_BRK_BIT] ? brk_win_q[c] : prog_running_i);
      inc[c] = active[c] ? sel_inc(ctrl_q[c][CTRL_MODE_LSB +: CTRL_MODE_W], ev_bits,
                                   iss_add, dual_add, fp_cnt) : 2'h0;
      psum[c] = presc_q[c] + {{(RATIO_W-1){1'b0}}, inc[c]};
      cnt_d[c] = cnt_q[c];
      presc_d[c] = presc_q[c];
      if (wr_cnt[c]) begin
        cnt_d[c] = wdata_i[CNT_W-1:0];
        presc_d[c] = '0;
      end else if (!ctrl_q[c][CTRL_CLK_BUS_BIT]) begin
        cnt_d[c] = cnt_q[c] + {{(CNT_W-2){1'b0}}, inc[c]};
      end else if (psum[c] >= {1'b0, ratio_eff}) begin
        cnt_d[c] = cnt_q[c] + {{(CNT_W-1){1'b0}}, 1'b1};
        presc_d[c] = psum[c] - {1'b0, ratio_eff};
      end else begin
        presc_d[c] = psum[c];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        ctrl_q[c] <= CTRL_RST;
        cnt_q[c] <= CNT_RST;
        presc_q[c] <= '0;
        brk_win_q[c] <= 1'b0;
      end
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (wr_ctrl[c]) begin
          ctrl_q[c] <= wdata_i[CTRL_W-1:0];
        end
        cnt_q[c] <= cnt_d[c];
        presc_q[c] <= presc_d[c];
        // Rising edges of break condition 4 alternately open and close the window
        if (wr_ctrl[c]) begin
          brk_win_q[c] <= brk_cond4_rise && wdata_i[CTRL_RANGE_BRK_BIT];
        end else if (brk_cond4_rise && ctrl_q[c][CTRL_RANGE_BRK_BIT]) begin
          brk_win_q[c] <= !brk_win_q[c];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      br_stall_seen_q <= 1'b0;
      brk_cond4_q <= 1'b0;
    end else begin
      br_stall_seen_q <= br_target_stall_i;
      brk_cond4_q <= brk_cond4_i;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt acceptance during break
  // ----------------------------------------------------------------
  wire logic user_irq_block = cont_trace_q && (emu_cmd_busy_i || in_break_i);
  wire logic nmi_ok_brk = irq_en_q;
  wire logic ext_ok_brk = irq_en_q && level_given_q && (ext_level_i > level_q);
  wire logic nmi_acc_d = nmi_req_i && !user_irq_block && (!in_break_i || nmi_ok_brk);
  wire logic ext_acc_d = ext_req_i && !user_irq_block && (!in_break_i || ext_ok_brk);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ratio_q <= RATIO_RST;
      irq_en_q <= 1'b0;
      level_given_q <= 1'b0;
      cont_trace_q <= 1'b0;
      level_q <= LEVEL_RST;
      nmi_acc_q <= 1'b0;
      ext_acc_q <= 1'b0;
    end else begin
      if (wr_ratio) begin
        ratio_q <= wdata_i[RATIO_W-1:0];
      end
      if (wr_irq) begin
        irq_en_q <= wdata_i[IRQ_ENABLE_BIT];
        level_given_q <= wdata_i[IRQ_LEVEL_GIVEN_BIT];
        cont_trace_q <= wdata_i[IRQ_CONT_TRACE_BIT];
        level_q <= wdata_i[IRQ_LEVEL_GIVEN_BIT] ? wdata_i[IRQ_LEVEL_LSB +: LEVEL_W] : LEVEL_RST;
      end
      nmi_acc_q <= nmi_acc_d;
      ext_acc_q <= ext_acc_d;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rmux;
  always_comb begin
    rmux = '0;
    unique case (addr_i)
      OFS_CH_CTRL0: rmux[CTRL_W-1:0] = ctrl_q[0];
      OFS_CH_CTRL1: rmux[CTRL_W-1:0] = ctrl_q[1];
      OFS_CH_COUNT0: rmux = cnt_q[0];
      OFS_CH_COUNT1: rmux = cnt_q[1];
      OFS_BUS_RATIO: rmux[RATIO_W-1:0] = ratio_q;
      OFS_BRK_IRQ_CFG: begin
        rmux[IRQ_ENABLE_BIT] = irq_en_q;
        rmux[IRQ_LEVEL_GIVEN_BIT] = level_given_q;
        rmux[IRQ_CONT_TRACE_BIT] = cont_trace_q;
        rmux[IRQ_LEVEL_LSB +: LEVEL_W] = level_q;
      end
      OFS_STATUS: begin
        rmux[ST_ACTIVE0_BIT] = active[0];
        rmux[ST_ACTIVE1_BIT] = active[1];
        rmux[ST_IN_BREAK_BIT] = in_break_i;
      end
      default: rmux = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? rmux : '0;
    end
  end

  assign rdata_o = rdata_q;
  assign nmi_accept_o = nmi_acc_q;
  assign ext_accept_o = ext_acc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire logic [CTRL_MODE_W-1:0] mode0 = ctrl_q[0][CTRL_MODE_LSB +: CTRL_MODE_W];
  wire logic cpu0 = ctrl_q[0][CTRL_EN_BIT] && !ctrl_q[0][CTRL_CLK_BUS_BIT] && !wr_cnt[0];

  touch_skip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && mode0 == M_OPND_ALL && cache_touch_instruction_i) |=> $stable(cnt_q[0]))
    else $error("cache touch access counted");
  imiss_uncached_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && active[0] && mode0 == M_IMISS && ifetch_uncached_slow_i) |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
    else $error("slow uncached fetch not counted");
  xlate_cancel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && active[0] && mode0 == M_DXLATE_MISS && dxlate_miss_cancel_i) |=> cnt_q[0] != $past(cnt_q[0]))
    else $error("cancelled miss not counted");
  dual_issue_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && active[0] && mode0 == M_ISSUE && !ifetch_exc_i && issue_v0_i && issue_v1_i)
    |=> cnt_q[0] == $past(cnt_q[0]) + 32'h2)
    else $error("dual issue not counted as two");
  exc_issue_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && active[0] && mode0 == M_DUAL_ISSUE && ifetch_exc_i)
    |=> (cnt_q[0] - $past(cnt_q[0]) >= 32'h1) && (cnt_q[0] - $past(cnt_q[0]) <= 32'h3))
    else $error("fetch exception issue add out of range");
  fp_opcode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && active[0] && mode0 == M_FP_ISSUE && issue_v0_i && !issue_v1_i && issue_op0_i[15:12] == 4'hf)
    |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
    else $error("fp opcode not counted");
  branch_late_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cpu0 && mode0 == M_FRZ_BRANCH && delay_slot_late_i && !exc_freeze_i) |=> $stable(cnt_q[0]))
    else $error("late delay slot branch counted");
  brk_disable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (in_break_i && !irq_en_q) |=> !nmi_accept_o && !ext_accept_o)
    else $error("interrupt accepted while disabled in break");
  brk_nmi_only_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (in_break_i && irq_en_q && !level_given_q && !cont_trace_q) |=> !ext_accept_o && (nmi_accept_o == $past(nmi_req_i)))
    else $error("break acceptance without level wrong");
  brk_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (in_break_i && irq_en_q && level_given_q && ext_req_i && ext_level_i <= level_q) |=> !ext_accept_o)
    else $error("masked level accepted in break");
  cont_trace_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cont_trace_q && emu_cmd_busy_i) |=> !nmi_accept_o && !ext_accept_o)
    else $error("user interrupt during command execution");

endmodule : perf_event_counter

// ===== perf_event_counter_pkg.sv
// Package for the event-selectable performance counters of the debug block.
// Assumes a single 20 MHz clock and a simple strobe register port.
package perf_event_counter_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 2;
  localparam int CNT_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEVEL_W = 8;
  localparam int RATIO_W = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CH_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CH_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CH_COUNT0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CH_COUNT1 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BUS_RATIO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BRK_IRQ_CFG = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 5;
  localparam int CTRL_CLK_BUS_BIT = 5;
  localparam int CTRL_RANGE_BRK_BIT = 6;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_W = 8;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int IRQ_LEVEL_GIVEN_BIT = 1;
  localparam int IRQ_CONT_TRACE_BIT = 2;
  localparam int IRQ_LEVEL_LSB = 8;
  localparam int ST_ACTIVE0_BIT = 0;
  localparam int ST_ACTIVE1_BIT = 1;
  localparam int ST_IN_BREAK_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [RATIO_W-1:0] RATIO_RST = 4'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Measurement modes, in register code order
  // ----------------------------------------------------------------
  typedef enum logic [CTRL_MODE_W-1:0] {
    M_OPND_RD, M_OPND_WR, M_OPND_RW, M_OPND_RAM, M_OPND_ALL, M_IO_ACC,
    M_DMISS_RD, M_DMISS_WR, M_DMISS_RW, M_IMISS, M_DXLATE_MISS, M_IXLATE_MISS,
    M_FETCH_CACHED, M_FETCH_ALL, M_BR_ISSUE, M_BR_TAKEN, M_CALL_ISSUE,
    M_ISSUE, M_DUAL_ISSUE, M_FP_ISSUE, M_TRAP, M_INT, M_NMI,
    M_BRK_A, M_BRK_B, M_IFILL, M_OFILL, M_TIME,
    M_FRZ_IMISS, M_FRZ_DMISS, M_FRZ_BRANCH
  } mode_t;

  localparam int NUM_MODES = 31;

endpackage : perf_event_counter_pkg

// ===== debug_host.sv
// Emulator host model: reaches the counter registers like debug software.
// Assumes the counter block answers a read one cycle after the strobe.
`timescale 1ns/1ns
module debug_host import perf_event_counter_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Register port, master side
  output logic [ADDR_W-1:0] addr_o = '0,
  output logic [DATA_W-1:0] wdata_o = '0,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  input wire logic [DATA_W-1:0] rdata_i
);
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : debug_host

// ===== perf_event_counter_test.sv
// Self-checking bench for the two-channel event counters and break interrupt gating.
// Assumes the debug_host model drives the register port; event pins come from ev.
`timescale 1ns/1ns
module perf_event_counter_test import perf_event_counter_pkg::*; ;
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i, rd_i, prog_running_i = 1'b1, brk_cond4_i = 1'b0;
  logic in_break_i = 1'b0, emu_cmd_busy_i = 1'b0, nmi_req_i = 1'b0, ext_req_i = 1'b0, nmi_accept_o, ext_accept_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, got;
  logic [15:0] issue_op0_i = 16'hf123, issue_op1_i = 16'h415a;
  logic [1:0] ifetch_exc_issue_i = 2'h3;
  logic [LEVEL_W-1:0] ext_level_i = 8'h00;
  logic [39:0] ev = 40'h0;
  int err_count = 0, cmp_count = 0, cycles = 0;
  typedef struct {mode_t m; logic [39:0] e; int n; logic [31:0] x;} row_t;
  row_t rows [24] = '{
    '{M_OPND_RD, 40'ha800000000, 1, 1}, '{M_OPND_RD, 40'hb800000000, 1, 0},
    '{M_OPND_RD, 40'ha000000000, 1, 0}, '{M_IMISS, 40'h0020000000, 1, 1},
    '{M_IMISS, 40'h0010000000, 1, 1}, '{M_DXLATE_MISS, 40'h0000800000, 1, 1},
    '{M_IXLATE_MISS, 40'h0000200000, 1, 1}, '{M_FETCH_CACHED, 40'h000c000000, 1, 1},
    '{M_FETCH_ALL, 40'h0008000000, 2, 2}, '{M_ISSUE, 40'h0000180000, 1, 2},
    '{M_FP_ISSUE, 40'h0000180000, 1, 2}, '{M_DUAL_ISSUE, 40'h0000040000, 1, 3},
    '{M_BRK_B, 40'h0000000400, 1, 1}, '{M_FRZ_IMISS, 40'h0000000080, 2, 2},
    '{M_FRZ_DMISS, 40'h0000000020, 1, 1}, '{M_FRZ_BRANCH, 40'h000000000c, 1, 0},
    '{M_FRZ_BRANCH, 40'h0000000008, 1, 1}, '{M_IFILL, 40'h0000000001, 3, 2},
    '{M_OPND_ALL, 40'h9800000000, 1, 0}, '{M_OPND_WR, 40'he800000000, 1, 1},
    '{M_DMISS_RD, 40'h1900000000, 1, 0}, '{M_FP_ISSUE, 40'h0000100000, 1, 1},
    '{M_IO_ACC, 40'h0200000000, 1, 1}, '{M_OFILL, 40'h0080000000, 2, 2}};

  perf_event_counter perf_event_counter_i (.*,
    .opnd_acc_i(ev[39]), .opnd_wr_i(ev[38]), .opnd_cache_area_i(ev[37]), .cache_touch_instruction_i(ev[36]),
    .page_cacheable_bit_i(ev[35]), .opnd_ram_i(ev[34]), .io_acc_i(ev[33]), .opnd_miss_i(ev[32]),
    .ofill_cycle_i(ev[31]), .imiss_i(ev[30]), .ifetch_uncached_slow_i(ev[29]), .overrun_imiss_i(ev[28]),
    .ifetch_accept_i(ev[27]), .ifetch_cache_area_i(ev[26]), .ifill_cycle_i(ev[25]), .dxlate_miss_i(ev[24]),
    .dxlate_miss_cancel_i(ev[23]), .ixlate_miss_i(ev[22]), .ixlate_miss_cancel_i(ev[21]), .issue_v0_i(ev[20]),
    .issue_v1_i(ev[19]), .ifetch_exc_i(ev[18]), .br_issue_i(ev[17]), .br_taken_i(ev[16]), .call_issue_i(ev[15]),
    .trap_exec_i(ev[14]), .int_taken_i(ev[13]), .nmi_taken_i(ev[12]), .break_chan_a_hit_i(ev[11]),
    .break_chan_b_hit_i(ev[10]), .frz_imiss_i(ev[9]), .frz_iuncached_i(ev[8]), .frz_iram_io_i(ev[7]),
    .frz_dmiss_i(ev[6]), .frz_duncached_i(ev[5]), .frz_dram_io_i(ev[4]), .branch_exec_i(ev[3]),
    .delay_slot_late_i(ev[2]), .exc_freeze_i(ev[1]), .br_target_stall_i(ev[0]));
  debug_host debug_host_i (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask : check

  task automatic irq(input logic [15:0] cfg, input logic brk, busy, input logic [7:0] lvl, input logic [1:0] x);
    debug_host_i.wr(OFS_BRK_IRQ_CFG, {16'h0, cfg});
    @(posedge clk_i);
    in_break_i <= brk;
    emu_cmd_busy_i <= busy;
    ext_level_i <= lvl;
    nmi_req_i <= 1'b1;
    ext_req_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    check({30'h0, nmi_accept_o, ext_accept_o}, {30'h0, x});
  endtask : irq

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      debug_host_i.wr(OFS_CH_CTRL0, {24'h0, 3'h4, rows[i].m});
      debug_host_i.wr(OFS_CH_COUNT0, 32'h0);
      @(posedge clk_i) ev <= rows[i].e;
      repeat (rows[i].n) @(posedge clk_i);
      ev <= 40'h0;
      debug_host_i.rd(OFS_CH_COUNT0, got);
      check(got, rows[i].x);
    end
    $display("event rows done");
    // Second reset in mid-run, then register defaults
    @(posedge clk_i) rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    debug_host_i.rd(OFS_CH_CTRL0, got);
    check(got, 32'h0);
    debug_host_i.rd(OFS_BUS_RATIO, got);
    check(got, 32'h1);
    debug_host_i.rd(8'h1c, got);
    check(got, 32'h0);
    $display("reset test done");
    // Channel 0 on cpu clock, channel 1 scaled by a bus ratio of 4
    debug_host_i.wr(OFS_BUS_RATIO, 32'h4);
    debug_host_i.wr(OFS_CH_CTRL0, {24'h0, 3'h4, M_BRK_A});
    debug_host_i.wr(OFS_CH_CTRL1, {24'h0, 3'h5, M_BRK_A});
    @(posedge clk_i) ev <= 40'h800;
    repeat (8) @(posedge clk_i);
    ev <= 40'h0;
    debug_host_i.rd(OFS_CH_COUNT0, got);
    check(got, 32'h8);
    debug_host_i.rd(OFS_CH_COUNT1, got);
    check(got, 32'h2);
    debug_host_i.rd(OFS_STATUS, got);
    check(got, 32'h3);
    $display("channel test done");
    // Range channel: each break condition 4 rise toggles the window
    debug_host_i.wr(OFS_CH_CTRL0, {24'h0, 3'h6, M_BRK_A});
    debug_host_i.wr(OFS_CH_COUNT0, 32'h0);
    @(posedge clk_i) ev <= 40'h800;
    brk_cond4_i <= 1'b1;
    @(posedge clk_i) brk_cond4_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    brk_cond4_i <= 1'b1;
    @(posedge clk_i) brk_cond4_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    ev <= 40'h0;
    debug_host_i.rd(OFS_CH_COUNT0, got);
    check(got, 32'h4);
    // Program-run range: nothing counts while the program is stopped
    debug_host_i.wr(OFS_CH_CTRL0, {24'h0, 3'h4, M_BRK_A});
    @(posedge clk_i) ev <= 40'h800;
    prog_running_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    ev <= 40'h0;
    prog_running_i <= 1'b1;
    debug_host_i.rd(OFS_CH_COUNT0, got);
    check(got, 32'h4);
    $display("range test done");
    debug_host_i.wr(OFS_BRK_IRQ_CFG, 32'h0501);
    debug_host_i.rd(OFS_BRK_IRQ_CFG, got);
    check(got, 32'h1);
    irq(16'h0000, 1'b1, 1'b0, 8'h10, 2'b00);
    irq(16'h0001, 1'b1, 1'b0, 8'h10, 2'b10);
    irq(16'h0503, 1'b1, 1'b0, 8'h06, 2'b11);
    irq(16'h0503, 1'b1, 1'b0, 8'h05, 2'b10);
    irq(16'h0003, 1'b1, 1'b0, 8'h01, 2'b11);
    irq(16'h0507, 1'b1, 1'b0, 8'h06, 2'b00);
    irq(16'h0007, 1'b0, 1'b1, 8'h06, 2'b00);
    irq(16'h0007, 1'b0, 1'b0, 8'h06, 2'b11);
    $display("interrupt test done");
    print_verdict();
  end
endmodule : perf_event_counter_test
